// file: lsc_map.svh
// Purpose: Constants for the linear sensor serial control block
// Assumes: Serial clock is the system clock, one bit per clock
// Notes: Included by the design only
`ifndef LSC_MAP_SVH
`define LSC_MAP_SVH
`define LSC_CMD_MAIN_RESET 8'h1b
`define LSC_CMD_BEGIN_INT 8'h08
`define LSC_CMD_SAMPLE 8'h10
`define LSC_CMD_DUMP 8'h02
`define LSC_CMD_SAMPLE_DUMP 8'h12
`define LSC_CMD_SAMPLE_DUMP_RESTART 8'h16
`define LSC_CMD_ABORT 8'h19
`define LSC_CMD_REG_WRITE_TOP 3'h2
`define LSC_CMD_REG_READ_TOP 3'h3
`define LSC_REG_MODE 5'h1f
`define LSC_MODE_SLEEP 8'h10
`define LSC_MODE_NORMAL 8'h00
`define LSC_MODE_SLEEP_BIT 4
`define LSC_BREAK_ZEROS 4'ha
`define LSC_RESET_REPEAT 2'h3
`define LSC_OUT_SETTLE 5'h1e
`define LSC_PIX_RESET_CLKS 5'h16
`define LSC_DUMP_DELAY 6'h2c
`define LSC_READ_DELAY 6'h04
`define LSC_PIXEL_COUNT 7'h66
`define LSC_FRAME_BITS 4'ha
`endif

// file: lsc_pkg.sv
// Purpose: Types for the linear sensor serial control block
// Assumes: Constants come from lsc_map.svh
// Notes: Holds the receiver and transmitter state enums
package lsc_pkg;
   typedef enum logic [1:0]
   {
      RX_IDLE = 2'b00,
      RX_DATA = 2'b01,
      RX_STOP = 2'b10
   } rx_state_e;
   typedef enum logic [1:0]
   {
      TX_IDLE = 2'b00,
      TX_WAIT = 2'b01,
      TX_SEND = 2'b10
   } tx_state_e;
   typedef logic [7:0] byte_t;
endpackage

// file: linear_sensor_serial_control.sv
// Purpose: Command receiver, interpreter, pixel sequencing and serial output of a linear sensor
// Assumes: clk_sys is the serial clock; serial_in sampled on each rising edge; pixel data from the array
// Notes: Analog effects appear only as control outputs
`timescale 1ns/1ps
`include "lsc_map.svh"

// Summary of operation
// - Break or three consecutive 0x1b bytes clear the command logic; the mode register keeps its value.
// - Output is undefined until thirty clocks after the command logic is cleared.
// - Writing 0x10 to the mode register enters sleep, powering down analog.
// - Writing 0x00 to the mode register leaves sleep for normal operation.
// - Sleep changes no digital state; commands including dumps still run.
// - Byte 0x08 releases pixel integrators from reset to start integrating.
// - 0x10 captures pixel values; 0x02 streams captured values out.
// - Begin-integration is accepted anytime after sample-hold, overlapping readout.
// - 0x12 samples and dumps; 0x16 samples, dumps and restarts integration.
// - Sample-hold or either compound command starts a pixel reset sequence.
// - Pixel reset lasts 22 clocks; no integration begins before it ends.
// - Serial interface keeps working during the pixel reset interval.
// - Ten or more consecutive zero bits form a break clearing the interpreter.
// - Each output byte is start bit, eight bits LSB first, stop bit.
// - Register write is 010 plus 5-bit address, then one data byte.
module linear_sensor_serial_control #(
   parameter int PIXELS = 102
)
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic serial_in,
   input wire lsc_pkg::byte_t pixelData,
   output logic [6:0] pixelIndex,
   output logic serial_out,
   output logic outValid,
   output logic analogPowerDown,
   output logic integrating,
   output logic sampleHold,
   output logic pixelReset
);
   import lsc_pkg::*;

   // ********************************
   // Receiver
   // ********************************
   rx_state_e rxState_r;
   logic [2:0] rxBit_r;
   byte_t rxShift_r;
   logic [3:0] zeroRun_r;
   logic byteStrobe_r;
   byte_t rxByte_r;
   logic breakStrobe_r;

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n || breakStrobe_r)
      begin
         rxState_r <= RX_IDLE;
         rxBit_r <= 3'h0;
         rxShift_r <= 8'h00;
         byteStrobe_r <= 1'b0;
         rxByte_r <= 8'h00;
      end
      else
      begin
         byteStrobe_r <= 1'b0;
         unique case (rxState_r)
            RX_IDLE:
               if (!serial_in)
               begin
                  rxState_r <= RX_DATA;
                  rxBit_r <= 3'h0;
               end
            RX_DATA:
            begin
               rxShift_r <= {serial_in, rxShift_r[7:1]};
               rxBit_r <= rxBit_r + 3'h1;
               if (rxBit_r == 3'h7)
                  rxState_r <= RX_STOP;
            end
            RX_STOP:
            begin
               rxState_r <= RX_IDLE;
               if (serial_in)
               begin
                  byteStrobe_r <= 1'b1;
                  rxByte_r <= rxShift_r;
               end
            end
            default:
               rxState_r <= RX_IDLE;
         endcase
      end
   end

   // Break detector counts zeros regardless of framing
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         zeroRun_r <= 4'h0;
         breakStrobe_r <= 1'b0;
      end
      else
      begin
         breakStrobe_r <= 1'b0;
         if (serial_in)
            zeroRun_r <= 4'h0;
         else if (zeroRun_r != `LSC_BREAK_ZEROS)
         begin
            zeroRun_r <= zeroRun_r + 4'h1;
            if (zeroRun_r == `LSC_BREAK_ZEROS - 4'h1)
               breakStrobe_r <= 1'b1;
         end
      end
   end

   // ********************************
   // Command interpreter
   // ********************************
   logic expectData_r;
   logic [4:0] regAddr_r;
   logic [1:0] resetRun_r;
   logic cmdClear;
   byte_t modeReg_r;
   logic wantDump;
   logic wantSample;
   logic wantStart;
   logic wantRead;

   function automatic logic isCmd(input byte_t b, input byte_t c);
      return b == c;
   endfunction

   wire logic cmdByte = byteStrobe_r && !expectData_r;
   assign wantSample = cmdByte && (isCmd(rxByte_r, `LSC_CMD_SAMPLE) || isCmd(rxByte_r, `LSC_CMD_SAMPLE_DUMP)
      || isCmd(rxByte_r, `LSC_CMD_SAMPLE_DUMP_RESTART));
   assign wantDump = cmdByte && (isCmd(rxByte_r, `LSC_CMD_DUMP) || isCmd(rxByte_r, `LSC_CMD_SAMPLE_DUMP)
      || isCmd(rxByte_r, `LSC_CMD_SAMPLE_DUMP_RESTART));
   assign wantStart = cmdByte && (isCmd(rxByte_r, `LSC_CMD_BEGIN_INT)
      || isCmd(rxByte_r, `LSC_CMD_SAMPLE_DUMP_RESTART));
   assign wantRead = cmdByte && rxByte_r[7:5] == `LSC_CMD_REG_READ_TOP;
   // Third consecutive main reset, or a break, clears interpreter, integration, sample-hold and transmitter
   assign cmdClear = breakStrobe_r || (cmdByte && isCmd(rxByte_r, `LSC_CMD_MAIN_RESET)
      && resetRun_r == `LSC_RESET_REPEAT - 2'h1);

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n || cmdClear)
      begin
         expectData_r <= 1'b0;
         regAddr_r <= 5'h00;
         resetRun_r <= 2'h0;
      end
      else if (byteStrobe_r)
      begin
         if (expectData_r)
            expectData_r <= 1'b0;
         else if (rxByte_r[7:5] == `LSC_CMD_REG_WRITE_TOP)
         begin
            expectData_r <= 1'b1;
            regAddr_r <= rxByte_r[4:0];
         end
         resetRun_r <= (cmdByte && isCmd(rxByte_r, `LSC_CMD_MAIN_RESET)) ? resetRun_r + 2'h1 : 2'h0;
      end
   end

   // Mode register survives command clears; sleep touches no digital state
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         modeReg_r <= `LSC_MODE_NORMAL;
      else if (byteStrobe_r && expectData_r && regAddr_r == `LSC_REG_MODE)
         modeReg_r <= rxByte_r;
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         analogPowerDown <= 1'b0;
      else
         analogPowerDown <= modeReg_r[`LSC_MODE_SLEEP_BIT];
   end

   // ********************************
   // Pixel reset and integration
   // ********************************
   logic [4:0] resetCnt_r;
   logic startPending_r;

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         resetCnt_r <= 5'h00;
         pixelReset <= 1'b1;
      end
      else if (wantSample)
      begin
         resetCnt_r <= `LSC_PIX_RESET_CLKS;
         pixelReset <= 1'b1;
      end
      else if (resetCnt_r != 5'h00)
         resetCnt_r <= resetCnt_r - 5'h01;
      else
         pixelReset <= !integrating;
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n || cmdClear)
      begin
         startPending_r <= 1'b0;
         integrating <= 1'b0;
      end
      else if (wantSample)
      begin
         integrating <= 1'b0;
         startPending_r <= wantStart;
      end
      else if (wantStart || startPending_r)
      begin
         if (resetCnt_r == 5'h00)
         begin
            integrating <= 1'b1;
            startPending_r <= 1'b0;
         end
         else
            startPending_r <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n || cmdClear)
         sampleHold <= 1'b0;
      else if (wantSample)
         sampleHold <= 1'b1;
   end

   // ********************************
   // Transmitter
   // ********************************
   tx_state_e txState_r;
   logic [5:0] txWait_r;
   logic [3:0] txBit_r;
   logic [9:0] txFrame_r;
   logic txIsDump_r;
   logic [4:0] settle_r;

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         settle_r <= `LSC_OUT_SETTLE;
      else if (cmdClear)
         settle_r <= `LSC_OUT_SETTLE;
      else if (settle_r != 5'h00)
         settle_r <= settle_r - 5'h01;
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         outValid <= 1'b0;
      else
         outValid <= settle_r == 5'h00 && !cmdClear;
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n || cmdClear)
      begin
         txState_r <= TX_IDLE;
         txWait_r <= 6'h00;
         txBit_r <= 4'h0;
         txFrame_r <= 10'h3ff;
         txIsDump_r <= 1'b0;
         pixelIndex <= 7'h00;
         serial_out <= 1'b1;
      end
      else
      begin
         serial_out <= txFrame_r[0];
         unique case (txState_r)
            TX_IDLE:
               if (wantDump || wantRead)
               begin
                  txState_r <= TX_WAIT;
                  txIsDump_r <= wantDump;
                  txWait_r <= wantDump ? `LSC_DUMP_DELAY : `LSC_READ_DELAY;
                  pixelIndex <= 7'h00;
               end
            TX_WAIT:
               if (txWait_r == 6'h01)
               begin
                  txState_r <= TX_SEND;
                  txBit_r <= 4'h0;
                  // Register reads return mode if the last written address was mode; otherwise zero
                  txFrame_r <= {1'b1, txIsDump_r ? pixelData : (regAddr_r == `LSC_REG_MODE ? modeReg_r
                     : 8'h00), 1'b0};
               end
               else
                  txWait_r <= txWait_r - 6'h01;
            TX_SEND:
            begin
               txFrame_r <= {1'b1, txFrame_r[9:1]};
               txBit_r <= txBit_r + 4'h1;
               if (txBit_r == `LSC_FRAME_BITS - 4'h1)
               begin
                  if (txIsDump_r && pixelIndex != 7'(PIXELS - 1))
                  begin
                     pixelIndex <= pixelIndex + 7'h01;
                     txWait_r <= 6'h01;
                     txState_r <= TX_WAIT;
                  end
                  else
                     txState_r <= TX_IDLE;
               end
            end
            default:
               txState_r <= TX_IDLE;
         endcase
      end
   end

   // ********************************
   // Checks
   // ********************************
   sequence sampleSeen;
      wantSample;
   endsequence

   a_reset_holds_start: assert property (@(posedge clk_sys) disable iff (!rst_n)
      sampleSeen |=> !integrating [*8])
      else $error("integration began during pixel reset");
   a_break_clears: assert property (@(posedge clk_sys) disable iff (!rst_n)
      breakStrobe_r |=> !expectData_r && !startPending_r)
      else $error("break did not clear interpreter");
   a_sleep_follows: assert property (@(posedge clk_sys) disable iff (!rst_n)
      byteStrobe_r && expectData_r && regAddr_r == `LSC_REG_MODE && rxByte_r == `LSC_MODE_SLEEP
      |=> ##1 analogPowerDown)
      else $error("sleep not entered");
   a_wake_follows: assert property (@(posedge clk_sys) disable iff (!rst_n)
      byteStrobe_r && expectData_r && regAddr_r == `LSC_REG_MODE && rxByte_r == `LSC_MODE_NORMAL
      |=> ##1 !analogPowerDown)
      else $error("sleep not left");
   a_pending_applies: assert property (@(posedge clk_sys) disable iff (!rst_n)
      startPending_r && resetCnt_r == 5'h00 && !wantSample && !cmdClear |=> integrating)
      else $error("pending start not applied");
   a_start_begins: assert property (@(posedge clk_sys) disable iff (!rst_n)
      wantStart && !wantSample && resetCnt_r == 5'h00 && !cmdClear |=> integrating)
      else $error("start not applied");
   a_sample_holds: assert property (@(posedge clk_sys) disable iff (!rst_n)
      wantSample && !cmdClear |=> sampleHold && pixelReset)
      else $error("sample not captured");
   a_frame_start_bit: assert property (@(posedge clk_sys) disable iff (!rst_n)
      txState_r == TX_SEND && txBit_r == 4'h0 && !cmdClear |=> !serial_out)
      else $error("missing start bit");
   a_output_settle: assert property (@(posedge clk_sys) disable iff (!rst_n)
      cmdClear |=> !outValid [*8])
      else $error("output valid too early");
endmodule

// file: lsc_host_model.sv
// Purpose: Scanner controller model driving the serial command line
// Assumes: Bits change on the falling clock edge
// Notes: Line idles high between frames
`timescale 1ns/1ps
module lsc_host_model #(
   parameter int SETTLE_CLKS = 25000
)
(
   input wire logic clk_sys,
   output logic serialIn
);
   initial serialIn = 1'b1;

   // ***************
   // Line primitives
   // ***************
   task automatic idle(input int n);
      repeat (n) @(negedge clk_sys) serialIn = 1'b1;
   endtask

   task automatic send_byte(input logic [7:0] b);
      @(negedge clk_sys) serialIn = 1'b0;
      for (int i = 0; i < 8; i++)
         @(negedge clk_sys) serialIn = b[i];
      @(negedge clk_sys) serialIn = 1'b1;
   endtask

   task automatic send_break();
      repeat (10) @(negedge clk_sys) serialIn = 1'b0;
      @(negedge clk_sys) serialIn = 1'b1;
   endtask

   // ***************
   // Sequences
   // ***************
   task automatic init_clear(input bit useBreak);
      idle(10);
      if (useBreak)
         send_break();
      else
         repeat (3) send_byte(8'h1b);
      idle(30);
      // Output-valid flag trails the thirty clocks by a few registers
      idle(4);
   endtask

   // Only sleep and normal values are written to mode
   task automatic write_reg(input logic [4:0] addr, input logic [7:0] data);
      send_byte({3'h2, addr});
      send_byte(data);
   endtask

   // Shortened analog recovery wait
   task automatic settle();
      idle(SETTLE_CLKS);
   endtask
endmodule

// file: linear_sensor_serial_control_test.sv
// Purpose: Self-checking bench for the linear sensor serial control
// Assumes: Pixel data modelled from the pixel index
// Notes: Pixel count cut to 4 to keep dumps short
`timescale 1ns/1ps
module linear_sensor_serial_control_test;
   import lsc_pkg::*;
   localparam int PIX = 4;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   wire logic serialIn;
   byte_t pixelData;
   logic [6:0] pixelIndex;
   logic serial_out, outValid, analogPowerDown, integrating, sampleHold, pixelReset;
   int failures = 0;
   int check_count = 0;
   int cycles = 0;

   assign pixelData = {1'b0, pixelIndex} ^ 8'ha5;

   lsc_host_model #(.SETTLE_CLKS(250)) HOST (.clk_sys(clk_sys), .serialIn(serialIn));

   linear_sensor_serial_control #(.PIXELS(PIX)) DUT (
      .clk_sys(clk_sys), .rst_n(rst_n), .serial_in(serialIn), .pixelData(pixelData),
      .pixelIndex(pixelIndex), .serial_out(serial_out), .outValid(outValid),
      .analogPowerDown(analogPowerDown), .integrating(integrating),
      .sampleHold(sampleHold), .pixelReset(pixelReset));

   initial forever #20 clk_sys = ~clk_sys;

   // ***************
   // Helpers
   // ***************
   task automatic complete_run();
      $display("failures=%0d check_count=%0d", failures, check_count);
      if (failures == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Hang guard well above the expected run
   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 8000)
      begin
         failures++;
         complete_run();
      end
   end

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp)
      begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic read_frames(input int n);
      logic [7:0] v;
      int k;
      for (int p = 0; p < n; p++)
      begin
         k = 0;
         while (serial_out !== 1'b0 && k < 100)
         begin
            @(negedge clk_sys);
            k++;
         end
         for (int i = 0; i < 8; i++)
         begin
            @(negedge clk_sys);
            v[i] = serial_out;
         end
         @(negedge clk_sys);
         check({7'h0, serial_out}, 8'h01);
         check(v, 8'(p) ^ 8'ha5);
      end
   endtask

   // Register read of the mode register, one framed byte back
   task automatic read_mode(input logic [7:0] exp);
      logic [7:0] v;
      HOST.send_byte(8'h7f);
      while (serial_out !== 1'b0)
         @(negedge clk_sys);
      for (int i = 0; i < 8; i++)
      begin
         @(negedge clk_sys);
         v[i] = serial_out;
      end
      check(v, exp);
   endtask

   // ***************
   // Scenarios
   // ***************
   task automatic t_init();
      check({7'h0, pixelReset}, 8'h01);
      check({7'h0, integrating}, 8'h00);
      HOST.init_clear(1'b0);
      check({7'h0, outValid}, 8'h01);
      HOST.settle();
   endtask

   task automatic t_begin();
      int k;
      HOST.send_byte(8'h08);
      k = 0;
      while (integrating !== 1'b1 && k < 8)
      begin
         @(negedge clk_sys);
         k++;
      end
      check(8'(k <= 3), 8'h01);
   endtask

   task automatic t_sample();
      int t0;
      HOST.send_byte(8'h10);
      t0 = cycles;
      HOST.idle(2);
      check({5'h0, sampleHold, pixelReset, integrating}, 8'h06);
      HOST.send_byte(8'h08);
      check({7'h0, integrating}, 8'h00);
      while (integrating !== 1'b1 && cycles - t0 < 40)
         @(negedge clk_sys);
      check(8'(cycles - t0 >= 22 && cycles - t0 <= 26), 8'h01);
      HOST.send_byte(8'h02);
      read_frames(PIX);
      check({7'h0, integrating}, 8'h01);
   endtask

   task automatic t_compound();
      logic [7:0] cmds [2] = '{8'h12, 8'h16};
      foreach (cmds[j])
      begin
         HOST.send_byte(cmds[j]);
         HOST.idle(2);
         check({6'h0, sampleHold, pixelReset}, 8'h03);
         read_frames(PIX);
         HOST.idle(4);
         check({7'h0, integrating}, 8'(cmds[j] == 8'h16));
      end
   endtask

   task automatic t_sleep();
      HOST.write_reg(5'h1f, 8'h10);
      HOST.idle(3);
      check({6'h0, analogPowerDown, integrating}, 8'h03);
      read_mode(8'h10);
      HOST.send_byte(8'h02);
      read_frames(PIX);
      HOST.write_reg(5'h05, 8'h00);
      HOST.idle(3);
      check({7'h0, analogPowerDown}, 8'h01);
      HOST.write_reg(5'h1f, 8'h00);
      HOST.idle(3);
      check({7'h0, analogPowerDown}, 8'h00);
      read_mode(8'h00);
      HOST.settle();
   endtask

   task automatic t_break();
      check({7'h0, pixelReset}, 8'h00);
      HOST.init_clear(1'b1);
      check({7'h0, outValid}, 8'h01);
      check({6'h0, sampleHold, integrating}, 8'h00);
      HOST.send_byte(8'h10);
      HOST.idle(2);
      check({6'h0, sampleHold, pixelReset}, 8'h03);
   endtask

   initial
   begin
      repeat (16) @(negedge clk_sys);
      rst_n = 1'b1;
      t_init();
      t_begin();
      t_sample();
      t_compound();
      t_sleep();
      t_break();
      complete_run();
   end
endmodule
